// ### logic/aglc_pkg.sv
package aglc_pkg;
	localparam int         NREG        = 10;
	localparam logic [3:0] IDX_TMO     = 4'h0;
	localparam logic [3:0] IDX_FMT     = 4'h1;
	localparam logic [3:0] IDX_CLK     = 4'h2;
	localparam logic [3:0] IDX_PWR     = 4'h3;
	localparam logic [3:0] IDX_LG      = 4'h4;
	localparam logic [3:0] IDX_RG      = 4'h5;
	localparam logic [3:0] IDX_LC1     = 4'h6;
	localparam logic [3:0] IDX_LC2     = 4'h7;
	localparam logic [3:0] IDX_MUX     = 4'h8;
	localparam logic [3:0] IDX_ATD     = 4'h9;
	localparam logic [3:0] IDX_NONE    = 4'hF;
	localparam logic [6:0] ADDR_TMO    = 7'h07;
	localparam logic [6:0] ADDR_FMT    = 7'h0B;
	localparam logic [6:0] ADDR_CLK    = 7'h0C;
	localparam logic [6:0] ADDR_PWR    = 7'h0D;
	localparam logic [6:0] ADDR_LG     = 7'h0E;
	localparam logic [6:0] ADDR_RG     = 7'h0F;
	localparam logic [6:0] ADDR_LC1    = 7'h10;
	localparam logic [6:0] ADDR_LC2    = 7'h11;
	localparam logic [6:0] ADDR_ATD    = 7'h12;
	localparam logic [6:0] ADDR_MUX    = 7'h15;
	localparam logic [NREG-1:0][8:0] RESET_REGS = {9'h032, 9'h001, 9'h000, 9'h07B, 9'h0CF,
		9'h0CF, 9'h000, 9'h022, 9'h022, 9'h000};
	localparam int BIT_TOD   = 3;
	localparam int BIT_HPD   = 8;
	localparam int BIT_MS    = 8;
	localparam int BIT_OSR   = 3;
	localparam int BIT_GLOBAL_POWER_DOWN  = 0;
	localparam int BIT_CONVERTER_DISABLE = 1;
	localparam int BIT_INPUT_BUFFER_POWER_DOWN = 6;
	localparam int BIT_ZC    = 8;
	localparam int BIT_LINK  = 8;
	localparam int BIT_MUTEL = 7;
	localparam int BIT_MUTER = 6;
	localparam int BIT_LEVEL_CTRL_ENABLE  = 8;
	localparam int CTRL_ADDR_LSB = 9;
	localparam logic [1:0] FMT_RJ  = 2'h0;
	localparam logic [1:0] WL_24   = 2'h2;
	localparam logic [1:0] WL_32   = 2'h3;
	localparam logic [2:0] RATIO_256 = 3'h2;
	localparam logic [2:0] RATIO_384 = 3'h3;
	localparam logic [2:0] RATIO_512 = 3'h4;
	localparam logic [2:0] RATIO_768 = 3'h5;
	localparam logic [9:0] FRAME_256 = 10'h100;
	localparam logic [9:0] FRAME_384 = 10'h180;
	localparam logic [9:0] FRAME_512 = 10'h200;
	localparam logic [9:0] FRAME_768 = 10'h300;
	localparam int         BCLK_HALF_SHIFT = 7;
	localparam logic [1:0] SEL_LIM = 2'h0;
	localparam logic [1:0] SEL_R   = 2'h1;
	localparam logic [1:0] SEL_L   = 2'h2;
	localparam logic [1:0] SEL_ST  = 2'h3;
	localparam logic [7:0] GAIN_MUTE    = 8'h00;
	localparam logic [7:0] GAIN_PGA_MIN = 8'hA5;
	localparam logic [7:0] GAIN_MAX     = 8'hFF;
	localparam logic [7:0] GAIN_DEFAULT = 8'hCF;
	localparam logic [7:0] LIM_RED_MAX  = 8'h5A;
	localparam logic [3:0] LCT_ALC_MAX  = 4'hD;
	localparam logic [4:0] LCT_FLOOR_DB = 5'h10;
	localparam logic [3:0] TIME_SAT_CODE = 4'hA;
	localparam int CLK_PERIOD_NS   = 8;
	localparam int ZC_TIMEOUT_MCLK = 131072;
	localparam int LIM_ATK_BASE_NS = 250000;
	localparam int LIM_DCY_BASE_NS = 1200000;
	localparam int ALC_ATK_BASE_NS = 8400000;
	localparam int ALC_DCY_BASE_NS = 33600000;
	localparam int LIM_STEPS = 12;
	localparam int ALC_STEPS = 81;
	localparam int LIM_ATK_CYC = LIM_ATK_BASE_NS / (CLK_PERIOD_NS * LIM_STEPS);
	localparam int LIM_DCY_CYC = LIM_DCY_BASE_NS / (CLK_PERIOD_NS * LIM_STEPS);
	localparam int ALC_ATK_CYC = ALC_ATK_BASE_NS / (CLK_PERIOD_NS * ALC_STEPS);
	localparam int ALC_DCY_CYC = ALC_DCY_BASE_NS / (CLK_PERIOD_NS * ALC_STEPS);

	typedef struct packed {
		logic [NREG-1:0][8:0] regs;
		logic [7:0]           lapp;
		logic [7:0]           rapp;
		logic                 lpend;
		logic                 rpend;
		logic [31:0]          lcnt;
		logic [31:0]          rcnt;
		logic [7:0]           red;
		logic [7:0]           alc_l;
		logic [7:0]           alc_r;
		logic [31:0]          step_cnt;
		logic [9:0]           div_cnt;
		logic [3:0]           bclk_cnt;
		logic                 wclk;
		logic                 bclk;
		logic                 clk_oe;
		logic [1:0]           eff_wl;
		logic                 osr;
		logic                 gpd;
		logic                 conv_pd;
		logic                 filt_rst;
		logic                 inbuf_pd;
		logic                 hpf_en;
		logic [7:0]           pga_l;
		logic [7:0]           pga_r;
		logic [7:0]           att_l;
		logic [7:0]           att_r;
		logic                 mute_l;
		logic                 mute_r;
		logic                 lc_on;
	} aglc_state_t;
endpackage : aglc_pkg

// ### logic/aglc_top.sv
`timescale 1ns/1ps
module aglc_top
	import aglc_pkg::*;
#(
	parameter int ZC_TIMEOUT = ZC_TIMEOUT_MCLK,
	parameter int LIM_ATK    = LIM_ATK_CYC,
	parameter int LIM_DCY    = LIM_DCY_CYC,
	parameter int ALC_ATK    = ALC_ATK_CYC,
	parameter int ALC_DCY    = ALC_DCY_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic [15:0] ctrl_word_in,
	input  wire logic        ctrl_wr_in,
	input  wire logic        left_zero_cross_in,
	input  wire logic        right_zero_cross_in,
	input  wire logic [4:0]  left_peak_in,
	input  wire logic [4:0]  right_peak_in,
	output logic             word_clock_out,
	output logic             word_clock_oe_out,
	output logic             bit_clock_out,
	output logic             bit_clock_oe_out,
	output logic [1:0]       word_length_out,
	output logic             oversample_select_out,
	output logic             global_power_down_out,
	output logic             converter_disable_out,
	output logic             filter_reset_out,
	output logic             input_buffer_power_down_out,
	output logic             highpass_enable_out,
	output logic [3:0]       input_select_out,
	output logic [7:0]       left_pga_out,
	output logic [7:0]       right_pga_out,
	output logic [7:0]       left_atten_out,
	output logic [7:0]       right_atten_out,
	output logic             left_mute_out,
	output logic             right_mute_out,
	output logic             left_pending_out,
	output logic             right_pending_out,
	output logic             level_ctrl_active_out
);
	aglc_state_t q;
	aglc_state_t d;

	function automatic logic [3:0] reg_index(input logic [6:0] addr);
		case (addr)
			ADDR_TMO: reg_index = IDX_TMO;
			ADDR_FMT: reg_index = IDX_FMT;
			ADDR_CLK: reg_index = IDX_CLK;
			ADDR_PWR: reg_index = IDX_PWR;
			ADDR_LG:  reg_index = IDX_LG;
			ADDR_RG:  reg_index = IDX_RG;
			ADDR_LC1: reg_index = IDX_LC1;
			ADDR_LC2: reg_index = IDX_LC2;
			ADDR_ATD: reg_index = IDX_ATD;
			ADDR_MUX: reg_index = IDX_MUX;
			default:  reg_index = IDX_NONE;
		endcase
	endfunction : reg_index

	function automatic logic [9:0] frame_len(input logic [2:0] ratio);
		case (ratio)
			RATIO_384: frame_len = FRAME_384;
			RATIO_512: frame_len = FRAME_512;
			RATIO_768: frame_len = FRAME_768;
			default:   frame_len = FRAME_256;
		endcase
	endfunction : frame_len

	function automatic logic [7:0] pga_of(input logic [7:0] code);
		pga_of = (code < GAIN_PGA_MIN) ? GAIN_PGA_MIN : code;
	endfunction : pga_of

	function automatic logic [7:0] att_of(input logic [7:0] code);
		att_of = (code < GAIN_PGA_MIN) ? 8'(GAIN_PGA_MIN - code) : GAIN_MUTE;
	endfunction : att_of

	function automatic logic [7:0] sub_floor(input logic [7:0] g, input logic [7:0] r);
		sub_floor = (g < 8'(GAIN_PGA_MIN + r)) || (r > LIM_RED_MAX) ? GAIN_PGA_MIN : 8'(g - r);
	endfunction : sub_floor

	function automatic logic [31:0] step_period(input int base, input logic [3:0] code);
		logic [3:0] sh;
		sh = (code > TIME_SAT_CODE) ? TIME_SAT_CODE : code;
		step_period = 32'(base) << sh;
	endfunction : step_period

	always_comb begin : next_state
		logic [3:0]  widx;
		logic        global_power_down;
		logic        master;
		logic        zero_cross_timeout_disable;
		logic [9:0]  frame;
		logic [3:0]  bhalf;
		logic [7:0]  base_l;
		logic [7:0]  base_r;
		logic        lc;
		logic        lim;
		logic        alc_l_on;
		logic        alc_r_on;
		logic [3:0]  level_threshold;
		logic [4:0]  thr;
		logic [4:0]  pk_max;
		logic        over_l;
		logic        over_r;
		logic        under_l;
		logic        under_r;
		logic        over;
		logic [31:0] period;
		logic        tick;
		widx = reg_index(ctrl_word_in[15:CTRL_ADDR_LSB]);
		global_power_down = q.regs[IDX_PWR][BIT_GLOBAL_POWER_DOWN];
		master = q.regs[IDX_CLK][BIT_MS] && !global_power_down;
		zero_cross_timeout_disable = q.regs[IDX_TMO][BIT_TOD];
		frame = frame_len(q.regs[IDX_CLK][2:0]);
		bhalf = 4'(frame >> BCLK_HALF_SHIFT);
		d = q;
		if (ctrl_wr_in && widx != IDX_NONE) begin
			d.regs[widx] = ctrl_word_in[8:0];
		end
		// Left gain update path
		if (ctrl_wr_in && widx == IDX_LG) begin
			if (ctrl_word_in[BIT_ZC]) begin
				d.lpend = 1'b1;
				d.lcnt = '0;
			end else begin
				d.lapp = ctrl_word_in[7:0];
				d.lpend = 1'b0;
			end
		end else if (q.lpend) begin
			if (left_zero_cross_in || (!zero_cross_timeout_disable && q.lcnt >= 32'(ZC_TIMEOUT - 1))) begin
				d.lapp = q.regs[IDX_LG][7:0];
				d.lpend = 1'b0;
			end else begin
				d.lcnt = 32'(q.lcnt + 32'h1);
			end
		end
		// Right gain update path
		if (ctrl_wr_in && widx == IDX_RG) begin
			if (ctrl_word_in[BIT_ZC]) begin
				d.rpend = 1'b1;
				d.rcnt = '0;
			end else begin
				d.rapp = ctrl_word_in[7:0];
				d.rpend = 1'b0;
			end
		end else if (q.rpend) begin
			if (right_zero_cross_in || (!zero_cross_timeout_disable && q.rcnt >= 32'(ZC_TIMEOUT - 1))) begin
				d.rapp = q.regs[IDX_RG][7:0];
				d.rpend = 1'b0;
			end else begin
				d.rcnt = 32'(q.rcnt + 32'h1);
			end
		end
		// Format, rate and power
		d.eff_wl = (q.regs[IDX_FMT][1:0] == FMT_RJ && q.regs[IDX_FMT][5:4] == WL_32)
			? WL_24 : q.regs[IDX_FMT][5:4];
		d.osr = q.regs[IDX_CLK][BIT_OSR];
		d.hpf_en = !q.regs[IDX_FMT][BIT_HPD];
		d.gpd = global_power_down;
		d.conv_pd = global_power_down || q.regs[IDX_PWR][BIT_CONVERTER_DISABLE];
		d.filt_rst = global_power_down || q.regs[IDX_PWR][BIT_CONVERTER_DISABLE];
		d.inbuf_pd = global_power_down || q.regs[IDX_PWR][BIT_INPUT_BUFFER_POWER_DOWN];
		// Master clock dividers
		d.clk_oe = master;
		if (!master) begin
			d.div_cnt = '0;
			d.bclk_cnt = '0;
			d.wclk = 1'b0;
			d.bclk = 1'b0;
		end else begin
			d.div_cnt = (q.div_cnt >= 10'(frame - 10'h1)) ? '0 : 10'(q.div_cnt + 10'h1);
			d.wclk = (d.div_cnt < (frame >> 1));
			if (q.bclk_cnt >= 4'(bhalf - 4'h1)) begin
				d.bclk_cnt = '0;
				d.bclk = !q.bclk;
			end else begin
				d.bclk_cnt = 4'(q.bclk_cnt + 4'h1);
			end
		end
		// Level control
		base_l = q.lapp;
		base_r = q.regs[IDX_MUX][BIT_LINK] ? q.lapp : q.rapp;
		lc = q.regs[IDX_LC2][BIT_LEVEL_CTRL_ENABLE] && !global_power_down;
		lim = lc && q.regs[IDX_LC1][8:7] == SEL_LIM;
		alc_l_on = lc && (q.regs[IDX_LC1][8:7] == SEL_L || q.regs[IDX_LC1][8:7] == SEL_ST);
		alc_r_on = lc && (q.regs[IDX_LC1][8:7] == SEL_R || q.regs[IDX_LC1][8:7] == SEL_ST);
		level_threshold = q.regs[IDX_LC1][3:0];
		if (!lim && level_threshold > LCT_ALC_MAX) begin
			level_threshold = LCT_ALC_MAX;
		end
		thr = 5'(LCT_FLOOR_DB - {1'b0, level_threshold});
		pk_max = (left_peak_in < right_peak_in) ? left_peak_in : right_peak_in;
		over_l = left_peak_in < thr;
		over_r = right_peak_in < thr;
		under_l = left_peak_in > thr;
		under_r = right_peak_in > thr;
		over = lim ? (pk_max < thr) : ((alc_l_on && over_l) || (alc_r_on && over_r));
		if (over) begin
			period = step_period(lim ? LIM_ATK : ALC_ATK, q.regs[IDX_ATD][3:0]);
		end else begin
			period = step_period(lim ? LIM_DCY : ALC_DCY, q.regs[IDX_ATD][7:4]);
		end
		tick = q.step_cnt >= 32'(period - 32'h1);
		d.step_cnt = (!lc || tick) ? '0 : 32'(q.step_cnt + 32'h1);
		if (!lim) begin
			d.red = '0;
		end else if (tick) begin
			if (over && q.red < LIM_RED_MAX) begin
				d.red = 8'(q.red + 8'h1);
			end else if (!over && q.red != 8'h00) begin
				d.red = 8'(q.red - 8'h1);
			end
		end
		if (!alc_l_on) begin
			d.alc_l = pga_of(base_l);
		end else if (tick) begin
			if (over_l && q.alc_l > GAIN_PGA_MIN) begin
				d.alc_l = 8'(q.alc_l - 8'h1);
			end else if (under_l && q.alc_l < GAIN_MAX) begin
				d.alc_l = 8'(q.alc_l + 8'h1);
			end
		end
		if (!alc_r_on) begin
			d.alc_r = pga_of(base_r);
		end else if (tick) begin
			if (over_r && q.alc_r > GAIN_PGA_MIN) begin
				d.alc_r = 8'(q.alc_r - 8'h1);
			end else if (under_r && q.alc_r < GAIN_MAX) begin
				d.alc_r = 8'(q.alc_r + 8'h1);
			end
		end
		d.pga_l = alc_l_on ? q.alc_l : sub_floor(pga_of(base_l), q.red);
		d.pga_r = alc_r_on ? q.alc_r : sub_floor(pga_of(base_r), q.red);
		d.att_l = att_of(base_l);
		d.att_r = att_of(base_r);
		d.mute_l = base_l == GAIN_MUTE || q.regs[IDX_MUX][BIT_MUTEL];
		d.mute_r = base_r == GAIN_MUTE || q.regs[IDX_MUX][BIT_MUTER];
		d.lc_on = lc;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '0;
			q.regs <= RESET_REGS;
			q.lapp <= GAIN_DEFAULT;
			q.rapp <= GAIN_DEFAULT;
			q.pga_l <= GAIN_DEFAULT;
			q.pga_r <= GAIN_DEFAULT;
			q.eff_wl <= WL_24;
			q.hpf_en <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign word_clock_out = q.wclk;
	assign word_clock_oe_out = q.clk_oe;
	assign bit_clock_out = q.bclk;
	assign bit_clock_oe_out = q.clk_oe;
	assign word_length_out = q.eff_wl;
	assign oversample_select_out = q.osr;
	assign global_power_down_out = q.gpd;
	assign converter_disable_out = q.conv_pd;
	assign filter_reset_out = q.filt_rst;
	assign input_buffer_power_down_out = q.inbuf_pd;
	assign highpass_enable_out = q.hpf_en;
	assign input_select_out = q.regs[IDX_MUX][3:0];
	assign left_pga_out = q.pga_l;
	assign right_pga_out = q.pga_r;
	assign left_atten_out = q.att_l;
	assign right_atten_out = q.att_r;
	assign left_mute_out = q.mute_l;
	assign right_mute_out = q.mute_r;
	assign left_pending_out = q.lpend;
	assign right_pending_out = q.rpend;
	assign level_ctrl_active_out = q.lc_on;

	property p_rj32;
		@(posedge clk_in) disable iff (srst_in)
		(q.regs[IDX_FMT][1:0] == FMT_RJ && q.regs[IDX_FMT][5:4] == WL_32) |=> word_length_out == WL_24;
	endproperty
	a_rj32: assert property (p_rj32) else $error("RJ 32-bit not reduced to 24");

	property p_master;
		@(posedge clk_in) disable iff (srst_in)
		(q.regs[IDX_CLK][BIT_MS] && !q.regs[IDX_PWR][BIT_GLOBAL_POWER_DOWN]) |=> word_clock_oe_out && bit_clock_oe_out;
	endproperty
	a_master: assert property (p_master) else $error("Master mode clocks not driven");

	property p_slave_quiet;
		@(posedge clk_in) disable iff (srst_in)
		!q.regs[IDX_CLK][BIT_MS] |=> !word_clock_oe_out && !word_clock_out;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("Slave mode drives clock");

	property p_gpd;
		@(posedge clk_in) disable iff (srst_in)
		q.regs[IDX_PWR][BIT_GLOBAL_POWER_DOWN] |=> converter_disable_out && input_buffer_power_down_out
			&& filter_reset_out && !level_ctrl_active_out;
	endproperty
	a_gpd: assert property (p_gpd) else $error("Global power-down not overriding");

	property p_conv;
		@(posedge clk_in) disable iff (srst_in)
		$fell(converter_disable_out) |-> !filter_reset_out && !global_power_down_out;
	endproperty
	a_conv: assert property (p_conv) else $error("Filter reset outlives disable");

	property p_pga_floor;
		@(posedge clk_in) disable iff (srst_in)
		left_pga_out >= GAIN_PGA_MIN && right_pga_out >= GAIN_PGA_MIN;
	endproperty
	a_pga_floor: assert property (p_pga_floor) else $error("PGA below minimum");

	property p_mute;
		@(posedge clk_in) disable iff (srst_in)
		q.regs[IDX_MUX][BIT_MUTEL] |=> left_mute_out;
	endproperty
	a_mute: assert property (p_mute) else $error("Left mute not applied");

	property p_timeout;
		@(posedge clk_in) disable iff (srst_in)
		(q.lpend && !q.regs[IDX_TMO][BIT_TOD] && q.lcnt >= 32'(ZC_TIMEOUT - 1) && !ctrl_wr_in)
			|=> !left_pending_out;
	endproperty
	a_timeout: assert property (p_timeout) else $error("Zero-cross timeout overrun");

	property p_hpf;
		@(posedge clk_in) disable iff (srst_in)
		q.regs[IDX_FMT][BIT_HPD] |=> !highpass_enable_out;
	endproperty
	a_hpf: assert property (p_hpf) else $error("High-pass not bypassed");

	property p_lim_ceiling;
		@(posedge clk_in) disable iff (srst_in)
		($past(q.lc_on) && $past(q.regs[IDX_LC1][8:7]) == SEL_LIM && $stable(q.lapp))
			|-> left_pga_out <= pga_of(q.lapp);
	endproperty
	a_lim_ceiling: assert property (p_lim_ceiling) else $error("Limiter raised gain");

	property p_link;
		@(posedge clk_in) disable iff (srst_in)
		($past(q.regs[IDX_MUX][BIT_LINK]) && !$past(q.lc_on) && !$past(q.regs[IDX_LC2][BIT_LEVEL_CTRL_ENABLE]))
			|-> right_pga_out == left_pga_out;
	endproperty
	a_link: assert property (p_link) else $error("Right PGA not following left");
endmodule : aglc_top

// ### tb/aglc_host.sv
`timescale 1ns/1ps
module aglc_host (
	input  wire logic        clk_in,
	output logic      [15:0] ctrl_word_out,
	output logic             ctrl_wr_out
);
	initial begin
		ctrl_word_out = 16'h0000;
		ctrl_wr_out   = 1'b0;
	end
	// One write, strobe for one cycle
	task automatic put(input logic [6:0] addr, input logic [8:0] data);
		@(negedge clk_in);
		ctrl_word_out = {addr, data};
		ctrl_wr_out   = 1'b1;
		@(negedge clk_in);
		ctrl_wr_out   = 1'b0;
		ctrl_word_out = ~ctrl_word_out;
	endtask : put
endmodule : aglc_host

// ### tb/test_adc_gain_level_control.sv
`timescale 1ns/1ps
module test_adc_gain_level_control
	import aglc_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [15:0] ctrl_word_in;
	logic        ctrl_wr_in;
	logic        left_zero_cross_in = 1'b0;
	logic        right_zero_cross_in = 1'b0;
	logic [4:0]  left_peak_in = 5'h1F;
	logic [4:0]  right_peak_in = 5'h1F;
	logic        word_clock_out, word_clock_oe_out, bit_clock_out, bit_clock_oe_out;
	logic [1:0]  word_length_out;
	logic        oversample_select_out, global_power_down_out, converter_disable_out;
	logic        filter_reset_out, input_buffer_power_down_out, highpass_enable_out;
	logic [3:0]  input_select_out;
	logic [7:0]  left_pga_out, right_pga_out, left_atten_out, right_atten_out;
	logic        left_mute_out, right_mute_out, left_pending_out, right_pending_out;
	logic        level_ctrl_active_out;
	logic [31:0] seed = 32'h723C;
	int          fails = 0;
	int          samples_checked = 0;
	logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'hA4, 8'hA5, 8'hCF, 8'hFF};
	logic [8:0]  pdv [3] = '{9'h001, 9'h002, 9'h040};
	logic [3:0]  pex [3] = '{4'hF, 4'h6, 4'h1};

	always #4 clk_in = ~clk_in;

	aglc_host host (.clk_in, .ctrl_word_out(ctrl_word_in), .ctrl_wr_out(ctrl_wr_in));

	aglc_top #(.ZC_TIMEOUT(16), .LIM_ATK(4), .LIM_DCY(4), .ALC_ATK(4), .ALC_DCY(4)) dut (
		.clk_in, .srst_in, .ctrl_word_in, .ctrl_wr_in, .left_zero_cross_in,
		.right_zero_cross_in, .left_peak_in, .right_peak_in, .word_clock_out,
		.word_clock_oe_out, .bit_clock_out, .bit_clock_oe_out, .word_length_out,
		.oversample_select_out, .global_power_down_out, .converter_disable_out,
		.filter_reset_out, .input_buffer_power_down_out, .highpass_enable_out,
		.input_select_out, .left_pga_out, .right_pga_out, .left_atten_out,
		.right_atten_out, .left_mute_out, .right_mute_out, .left_pending_out,
		.right_pending_out, .level_ctrl_active_out);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] exp_pga(input logic [7:0] c);
		return (c >= GAIN_PGA_MIN) ? c : GAIN_PGA_MIN;
	endfunction : exp_pga
	function automatic logic [7:0] exp_att(input logic [7:0] c);
		return (c >= GAIN_PGA_MIN) ? 8'h00 : GAIN_PGA_MIN - c;
	endfunction : exp_att

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wt
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		host.put(a, d);
		wt(2);
	endtask : wr
	task automatic tend(input string n);
		$display("test %s finished", n);
	endtask : tend
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// Clock period in cycles, from second to third rising edge
	task automatic meas(input bit bc, output int per);
		int k;
		int t0;
		int rises;
		logic p;
		logic s;
		per = 0;
		t0 = 0;
		rises = 0;
		p = bc ? bit_clock_out : word_clock_out;
		for (k = 0; k < 4000 && per == 0; k++) begin
			@(negedge clk_in);
			s = bc ? bit_clock_out : word_clock_out;
			if (!p && s) begin
				rises++;
				if (rises == 2) t0 = k;
				else if (rises == 3) per = k - t0;
			end
			p = s;
		end
	endtask : meas

	initial begin
		#(8 * 40000);
		fails++;
		wrap_up();
	end

	initial begin
		logic [7:0] c;
		int per;
		int f;
		int pw;
		wt(16);
		srst_in = 1'b0;
		wt(1);
		chk({left_pga_out, right_pga_out}, 16'hCFCF, "rst pga");
		chk({highpass_enable_out, word_length_out, oversample_select_out, global_power_down_out,
			converter_disable_out, input_buffer_power_down_out, word_clock_oe_out,
			level_ctrl_active_out}, 9'h180, "rst ctl");
		chk(input_select_out, 4'h1, "rst mux");
		tend("reset");
		for (int i = 0; i < 12; i++) begin
			c = (i < 6) ? codes[i] : 8'(rnd());
			wr(ADDR_LG, {1'b0, c});
			wr(ADDR_RG, {1'b0, ~c});
			chk(left_pga_out, exp_pga(c), "pga l");
			if (c != 8'h00) chk(left_atten_out, exp_att(c), "att l");
			chk(left_mute_out, c == 8'h00, "mute l");
			chk(right_pga_out, exp_pga(~c), "pga r");
			if (c != 8'hFF) chk(right_atten_out, exp_att(~c), "att r");
		end
		wr(7'h7F, 9'h000);
		chk(left_pga_out, exp_pga(c), "unmapped");
		tend("gain");
		wr(ADDR_LG, 9'h0D0);
		wr(ADDR_RG, 9'h0B0);
		wr(ADDR_MUX, 9'h08A);
		chk({left_mute_out, right_mute_out, input_select_out}, 6'h2A, "mute");
		wr(ADDR_MUX, 9'h14A);
		chk({left_mute_out, right_mute_out}, 2'h1, "mute r");
		chk(right_pga_out, 8'hD0, "link");
		wr(ADDR_MUX, 9'h001);
		chk(right_pga_out, 8'hB0, "unlink");
		tend("mute");
		wr(ADDR_FMT, 9'h030);
		chk(word_length_out, WL_24, "rj32");
		wr(ADDR_FMT, 9'h132);
		chk({highpass_enable_out, word_length_out}, 3'h3, "i2s32");
		wr(ADDR_FMT, 9'h022);
		chk(highpass_enable_out, 1'b1, "hpf");
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_PWR, pdv[i]);
			chk({global_power_down_out, converter_disable_out, filter_reset_out,
				input_buffer_power_down_out}, pex[i], "pwr");
		end
		wr(ADDR_PWR, 9'h000);
		chk({filter_reset_out, left_pga_out}, 9'h0D0, "wake");
		tend("format power");
		for (int r = 2; r < 6; r++) begin
			wr(ADDR_CLK, 9'h100 | 9'(r) | (9'(r & 1) << 3));
			chk({word_clock_oe_out, bit_clock_oe_out, oversample_select_out},
				{2'b11, 1'(r & 1)}, "master");
			f = 128 * ((r == 5) ? 6 : r);
			meas(1'b0, pw);
			chk(16'(pw), 16'(f), "frame");
			meas(1'b1, per);
			chk(16'(per), 16'(f / 64), "bitclk");
			chk(16'(pw >= 48 * per), 16'h1, "half24");
		end
		wr(ADDR_CLK, 9'h022);
		chk({word_clock_oe_out, bit_clock_oe_out}, 2'h0, "slave");
		tend("clocks");
		wr(ADDR_LG, 9'h0CF);
		host.put(ADDR_LG, 9'h1A0);
		chk(left_pending_out, 1'b1, "pend");
		wt(9);
		host.put(ADDR_LG, 9'h1B0);
		wt(10);
		chk({left_pending_out, left_pga_out}, 9'h1CF, "restart");
		wt(8);
		chk({left_pending_out, left_pga_out}, 9'h0B0, "timeout");
		host.put(ADDR_LG, 9'h1C0);
		wt(3);
		left_zero_cross_in = 1'b1;
		wt(2);
		left_zero_cross_in = 1'b0;
		chk({left_pending_out, left_pga_out}, 9'h0C0, "zc");
		host.put(ADDR_RG, 9'h1C4);
		chk(right_pending_out, 1'b1, "pend r");
		right_zero_cross_in = 1'b1;
		wt(2);
		right_zero_cross_in = 1'b0;
		chk({right_pending_out, right_pga_out}, 9'h0C4, "zc r");
		wr(ADDR_TMO, 9'h008);
		host.put(ADDR_LG, 9'h1D0);
		wt(40);
		chk({left_pending_out, left_pga_out}, 9'h1C0, "tod");
		left_zero_cross_in = 1'b1;
		wt(2);
		left_zero_cross_in = 1'b0;
		wr(ADDR_TMO, 9'h000);
		tend("zero cross");
		wr(ADDR_ATD, 9'h000);
		wr(ADDR_LG, 9'h0CF);
		wr(ADDR_RG, 9'h0CF);
		wr(ADDR_LC1, 9'h00B);
		wr(ADDR_LC2, 9'h100);
		chk(level_ctrl_active_out, 1'b1, "lc on");
		for (int k = 0; k < 660; k++) begin
			left_peak_in = (k < 60) ? 5'h00 : 5'(rnd() % 26 + 6);
			right_peak_in = (k < 60) ? 5'h14 : 5'(rnd() % 26 + 6);
			wt(1);
			chk({left_pga_out == right_pga_out, left_pga_out <= 8'hCF}, 2'h3, "lim");
			if (k == 59) chk(left_pga_out < 8'hCF, 1'b1, "atk");
		end
		chk(left_pga_out, 8'hCF, "dcy");
		wr(ADDR_RG, 9'h0B0);
		wr(ADDR_LC1, 9'h10B);
		left_peak_in = 5'h00;
		for (int k = 0; k < 100; k++) begin
			wt(1);
			chk(right_pga_out, 8'hB0, "alc r");
		end
		chk(left_pga_out < 8'hCF, 1'b1, "alc l");
		wr(ADDR_LC2, 9'h000);
		chk(level_ctrl_active_out, 1'b0, "lc off");
		wr(ADDR_ATD, 9'h001);
		left_peak_in = 5'h02;
		wr(ADDR_LC1, 9'h10F);
		wr(ADDR_LC2, 9'h100);
		c = left_pga_out;
		per = 0;
		f = 0;
		for (int k = 0; k < 64 && f < 2; k++) begin
			wt(1);
			if (left_pga_out != c) begin
				f++;
				per = (f == 1) ? k : k - per;
				c = left_pga_out;
			end
		end
		chk(16'(per), 16'h8, "atk step");
		chk(left_pga_out < 8'hCF, 1'b1, "alc clamp");
		wr(ADDR_LC2, 9'h000);
		tend("level control");
		wrap_up();
	end
endmodule : test_adc_gain_level_control
